// ===== design/begm_grant_mask.sv
// Workaround gating between bridge arbiter and processor/PCI buses
`timescale 1ns/1ps
module begm_grant_mask
  import begm_pkg::*;
#(
  parameter int DISC_CLKS = BEGM_DISC_PCI_CLKS
)
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // Configuration
  input  wire logic       async_l2_i,
  input  wire logic       flush_snoop_i,
  // PCI side
  input  wire logic       pci_clk_i,
  input  wire logic       pci_frame_n_i,
  input  wire logic [1:0] pci_ad_hi_i,
  input  wire logic [3:0] pci_cbe_n_i,
  input  wire logic       pci_gnt_n_i,
  input  wire logic       pci_stop_n_i,
  input  wire logic       pci_master_mem_i,
  // Bridge arbiter side
  input  wire logic       bridge_grant_cpu1_n_i,
  input  wire logic       bridge_grant_cpu2_n_i,
  input  wire logic       bridge_request_cpu1_n_i,
  input  wire logic       bridge_request_cpu2_n_i,
  input  wire logic       bridge_ta_n_i,
  input  wire logic       bridge_ta_oe_i,
  input  wire logic [4:0] bridge_tt_i,
  // Processor bus side
  input  wire logic       address_acknowledge_n_i,
  input  wire logic       address_bus_busy_n_i,
  input  wire logic       data_bus_busy_n_i,
  input  wire logic       proc_target_claim_n_i,
  input  wire logic [4:0] transfer_type_i,
  // Outputs
  output logic            bus_grant_cpu1_n_o,
  output logic            bus_grant_cpu2_n_o,
  output logic            bus_request_cpu1_n_o,
  output logic            bus_request_cpu2_n_o,
  output logic            bridge_frame_n_o,
  output logic [1:0]      bridge_ad_hi_o,
  output logic [3:0]      bridge_cbe_n_o,
  output logic            proc_addr0_o,
  output logic            proc_addr0_oe_o,
  output logic [4:0]      snoop_tt_o,
  output logic            transfer_acknowledge_n_o,
  output logic            transfer_acknowledge_oe_o
);
  initial
  begin
    if (DISC_CLKS < 1 || DISC_CLKS > 7)
      $error("DISC_CLKS out of range");
  end

  typedef struct packed {
    logic       g1;
    logic       g2;
    logic       r1;
    logic       r2;
    logic       frame;
    logic [1:0] adhi;
    logic [3:0] cbe;
    logic       a0oe;
    logic [4:0] tt;
    logic       ta;
    logic       taoe;
    logic       address_acknowledge_n_d;
    logic       abb_d;
    logic [2:0] disc;
    logic       gnt_d;
    logic       l2_mask;
    logic [1:0] abb_cnt;
    logic       eci_done;
  } begm_state_s;

  begm_state_s st;
  begm_state_s next_st;
  logic        pci_high;
  logic        pci_rise;
  logic        pci_fall;

  begm_pci_sync u_sync (
    .sys_clk_i  (sys_clk_i),
    .rst_b_i    (rst_b_i),
    .pci_clk_i  (pci_clk_i),
    .pci_high_o (pci_high),
    .pci_rise_o (pci_rise),
    .pci_fall_o (pci_fall)
  );

  function automatic logic is_eci(input logic [4:0] tt);
    is_eci = (tt & BEGM_TT_ECI_MASK) == BEGM_TT_ECI_VAL;
  endfunction : is_eci

  logic address_acknowledge_n_now;
  logic abb_fall;
  logic mask_gnt;
  logic mask_req;
  always_comb
  begin
    address_acknowledge_n_now = ~address_acknowledge_n_i;
    abb_fall = ~address_bus_busy_n_i & st.abb_d;
    next_st  = st;
    next_st.address_acknowledge_n_d = address_acknowledge_n_now;
    next_st.abb_d  = address_bus_busy_n_i;
    next_st.gnt_d  = pci_gnt_n_i;
    if (pci_master_mem_i && !pci_stop_n_i && st.disc == BEGM_RST_CNT)
      next_st.disc = 3'(DISC_CLKS);
    else if (pci_rise && st.disc != BEGM_RST_CNT)
      next_st.disc = st.disc - 3'h1;
    if (async_l2_i && pci_gnt_n_i && !st.gnt_d)
    begin
      next_st.l2_mask = 1'b1;
      next_st.abb_cnt = 2'h0;
    end
    else if (st.l2_mask && abb_fall)
    begin
      next_st.abb_cnt = st.abb_cnt + 2'h1;
      if (st.abb_cnt == 2'(BEGM_ABB_COUNT - 1))
        next_st.l2_mask = 1'b0;
    end
    mask_gnt = address_acknowledge_n_now | (st.disc != BEGM_RST_CNT)
             | (st.l2_mask & ~data_bus_busy_n_i);
    mask_req = pci_master_mem_i & pci_high;
    next_st.g1 = bridge_grant_cpu1_n_i | mask_gnt;
    next_st.g2 = bridge_grant_cpu2_n_i | mask_gnt;
    next_st.r1 = bridge_request_cpu1_n_i | mask_req;
    next_st.r2 = bridge_request_cpu2_n_i | mask_req;
    // Frame only passes active once the PCI clock is in its low half
    if (pci_frame_n_i)
      next_st.frame = 1'b1;
    else if (pci_fall)
      next_st.frame = 1'b0;
    if (pci_rise || !pci_master_mem_i)
    begin
      next_st.adhi = pci_ad_hi_i;
      next_st.cbe  = pci_cbe_n_i;
    end
    next_st.a0oe = address_acknowledge_n_now;
    next_st.tt = (flush_snoop_i && bridge_tt_i == BEGM_TT_WR_KILL)
               ? BEGM_TT_WR_FLUSH : bridge_tt_i;
    // After the first beat of an external-control op, acks are swallowed
    if (data_bus_busy_n_i)
      next_st.eci_done = 1'b0;
    else if (is_eci(transfer_type_i) && !bridge_ta_n_i)
      next_st.eci_done = 1'b1;
    next_st.ta   = bridge_ta_n_i | st.eci_done;
    next_st.taoe = bridge_ta_oe_i & proc_target_claim_n_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      st         <= '0;
      st.g1      <= 1'b1;
      st.g2      <= 1'b1;
      st.r1      <= 1'b1;
      st.r2      <= 1'b1;
      st.frame   <= 1'b1;
      st.cbe     <= 4'hf;
      st.ta      <= 1'b1;
      st.abb_d   <= 1'b1;
      st.gnt_d   <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign bus_grant_cpu1_n_o        = st.g1;
  assign bus_grant_cpu2_n_o        = st.g2;
  assign bus_request_cpu1_n_o      = st.r1;
  assign bus_request_cpu2_n_o      = st.r2;
  assign bridge_frame_n_o          = st.frame;
  assign bridge_ad_hi_o            = st.adhi;
  assign bridge_cbe_n_o            = st.cbe;
  assign proc_addr0_o              = 1'b0;
  assign proc_addr0_oe_o           = st.a0oe;
  assign snoop_tt_o                = st.tt;
  assign transfer_acknowledge_n_o  = st.ta;
  assign transfer_acknowledge_oe_o = st.taoe;

  property p_gnt_after_address_acknowledge_n;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      !address_acknowledge_n_i |=> bus_grant_cpu1_n_o && bus_grant_cpu2_n_o;
  endproperty
  a_gnt_after_address_acknowledge_n: assert property (p_gnt_after_address_acknowledge_n) else $error("grant during address_acknowledge_n");

  property p_a0_low;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      !address_acknowledge_n_i |=> proc_addr0_oe_o && !proc_addr0_o;
  endproperty
  a_a0_low: assert property (p_a0_low) else $error("addr0 not driven low");

  property p_disc_mask;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.disc != BEGM_RST_CNT) |=> bus_grant_cpu1_n_o;
  endproperty
  a_disc_mask: assert property (p_disc_mask) else $error("grant during disconnect");

  property p_req_mask;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (pci_master_mem_i && pci_high) |=> bus_request_cpu1_n_o && bus_request_cpu2_n_o;
  endproperty
  a_req_mask: assert property (p_req_mask) else $error("request while pci high");

  property p_frame_hold;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(bridge_frame_n_o) |-> $past(pci_fall);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame passed early");

  property p_snoop;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (flush_snoop_i && bridge_tt_i == BEGM_TT_WR_KILL) |=> snoop_tt_o == BEGM_TT_WR_FLUSH;
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop type not flush");

  property p_ta_claim;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      !proc_target_claim_n_i |=> !transfer_acknowledge_oe_o;
  endproperty
  a_ta_claim: assert property (p_ta_claim) else $error("ta driven on claim");

  property p_eci_one;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      st.eci_done |=> transfer_acknowledge_n_o;
  endproperty
  a_eci_one: assert property (p_eci_one) else $error("extra ack on ext ctl");

  property p_or;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      bridge_grant_cpu2_n_i |=> bus_grant_cpu2_n_o;
  endproperty
  a_or: assert property (p_or) else $error("grant not ORed");

  property p_l2;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (st.l2_mask && !data_bus_busy_n_i) |=> bus_grant_cpu1_n_o;
  endproperty
  a_l2: assert property (p_l2) else $error("grant during async l2 mask");

  property p_sample;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (pci_master_mem_i && !pci_rise) |=> $stable(bridge_cbe_n_o);
  endproperty
  a_sample: assert property (p_sample) else $error("cbe sampled off edge");
endmodule : begm_grant_mask

// ===== design/begm_pci_sync.sv
// PCI clock observer: three-flop synchroniser and edge pulses
`timescale 1ns/1ps
module begm_pci_sync
  import begm_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  // Observed PCI clock
  input  wire logic pci_clk_i,
  // Synchronised level and edges
  output logic      pci_high_o,
  output logic      pci_rise_o,
  output logic      pci_fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } begm_sync_s;

  begm_sync_s st;
  begm_sync_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.s1   = pci_clk_i;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = st.s2 & ~st.s3;
    next_st.fall = ~st.s2 & st.s3;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign pci_high_o = st.s3;
  assign pci_rise_o = st.rise;
  assign pci_fall_o = st.fall;
endmodule : begm_pci_sync

// ===== design/begm_pkg.sv
// Package with constants for the bridge grant masking workaround logic
package begm_pkg;
  localparam int          BEGM_DISC_PCI_CLKS = 6;
  localparam int          BEGM_ABB_COUNT     = 2;
  localparam logic [4:0]  BEGM_TT_WR_FLUSH   = 5'h02;
  localparam logic [4:0]  BEGM_TT_WR_KILL    = 5'h06;
  localparam logic [4:0]  BEGM_TT_ECI_MASK   = 5'h1b;
  localparam logic [4:0]  BEGM_TT_ECI_VAL    = 5'h12;
  localparam int          BEGM_ECI_BEATS     = 1;
  localparam logic [2:0]  BEGM_RST_CNT       = 3'h0;
endpackage : begm_pkg

// ===== tb/begm_pci_agent.sv
// PCI clock and busmaster agent for the grant masking bench
`timescale 1ns/1ps
module begm_pci_agent
(
  // Bench commands
  input  wire logic go_i,
  input  wire logic disc_i,
  // PCI bus
  output logic      pci_clk_o,
  output logic      frame_n_o,
  output logic      stop_n_o,
  output logic      master_mem_o
);
  // 30 ns keeps the ratio to the 8 ns bus clock away from 3:1
  initial pci_clk_o = 1'b0;
  always #15 pci_clk_o = ~pci_clk_o;
  initial {frame_n_o, stop_n_o, master_mem_o} = 3'h6;
  // No configuration writes are issued, so target data latching is never exercised
  always @(posedge pci_clk_o)
  begin
    frame_n_o    <= ~go_i;
    master_mem_o <= go_i;
    stop_n_o     <= ~(go_i & disc_i);
  end
endmodule : begm_pci_agent

// ===== tb/test_bridge_errata_grant_masking.sv
// Self-checking bench for the grant masking workaround logic
`timescale 1ns/1ps
module test_bridge_errata_grant_masking;
  import begm_pkg::*;
  localparam int DISC = 3;
  logic       sys_clk_i = 1'b0, rst_b_i = 1'b0, async_l2_i = 1'b0, flush_snoop_i = 1'b0;
  logic       go = 1'b0, disc = 1'b0, bg_n = 1'b0, br_n = 1'b1;
  logic [1:0] ad_hi = 2'h2;
  logic [3:0] cbe_n = 4'h5;
  logic       pci_clk_i, pci_frame_n_i, pci_stop_n_i, pci_master_mem_i;
  logic       pci_gnt_n_i = 1'b0, bridge_ta_n_i = 1'b1, bridge_ta_oe_i = 1'b0;
  logic       address_acknowledge_n_i = 1'b1, address_bus_busy_n_i = 1'b1;
  logic       data_bus_busy_n_i = 1'b1, proc_target_claim_n_i = 1'b1;
  logic [4:0] bridge_tt_i = 5'h0, transfer_type_i = 5'h0, snoop_tt_o;
  logic       bus_grant_cpu1_n_o, bus_grant_cpu2_n_o, bus_request_cpu1_n_o;
  logic       bus_request_cpu2_n_o, bridge_frame_n_o, proc_addr0_o, proc_addr0_oe_o;
  logic       transfer_acknowledge_n_o, transfer_acknowledge_oe_o;
  logic [1:0] bridge_ad_hi_o;
  logic [3:0] bridge_cbe_n_o;
  int         n_mismatch = 0, n_compared = 0, cnt;
  wire  [4:0] grants = {3'h0, bus_grant_cpu1_n_o, bus_grant_cpu2_n_o};
  wire  [4:0] reqs   = {3'h0, bus_request_cpu1_n_o, bus_request_cpu2_n_o};
  wire  [4:0] ta     = {3'h0, transfer_acknowledge_oe_o, transfer_acknowledge_n_o};
  begm_pci_agent u_pci
  (
    .go_i(go), .disc_i(disc), .pci_clk_o(pci_clk_i), .frame_n_o(pci_frame_n_i),
    .stop_n_o(pci_stop_n_i), .master_mem_o(pci_master_mem_i)
  );
  begm_grant_mask #(.DISC_CLKS(DISC)) u_dut
  (
    .sys_clk_i, .rst_b_i, .async_l2_i, .flush_snoop_i, .pci_clk_i, .pci_frame_n_i,
    .pci_ad_hi_i(ad_hi), .pci_cbe_n_i(cbe_n), .pci_gnt_n_i, .pci_stop_n_i, .pci_master_mem_i,
    .bridge_grant_cpu1_n_i(bg_n), .bridge_grant_cpu2_n_i(bg_n),
    .bridge_request_cpu1_n_i(br_n), .bridge_request_cpu2_n_i(br_n),
    .bridge_ta_n_i, .bridge_ta_oe_i, .bridge_tt_i, .address_acknowledge_n_i,
    .address_bus_busy_n_i, .data_bus_busy_n_i, .proc_target_claim_n_i, .transfer_type_i,
    .bus_grant_cpu1_n_o, .bus_grant_cpu2_n_o, .bus_request_cpu1_n_o, .bus_request_cpu2_n_o,
    .bridge_frame_n_o, .bridge_ad_hi_o, .bridge_cbe_n_o, .proc_addr0_o, .proc_addr0_oe_o,
    .snoop_tt_o, .transfer_acknowledge_n_o, .transfer_acknowledge_oe_o
  );
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_stop;
    for (int i = 0; i < 12 && pci_stop_n_i; i++)
      tick();
    if (pci_stop_n_i)
      chk(5'h1f, 5'h0);
  endtask : wait_stop
  task automatic t_address_acknowledge_n;
    address_acknowledge_n_i = 1'b0;
    tick();
    address_acknowledge_n_i = 1'b1;
    chk(grants, 5'h3);
    chk({3'h0, proc_addr0_oe_o, proc_addr0_o}, 5'h2);
    tick(2);
    chk(grants, 5'h0);
  endtask : t_address_acknowledge_n
  task automatic t_snoop;
    for (int f = 0; f < 2; f++)
    begin
      flush_snoop_i = f[0];
      bridge_tt_i = BEGM_TT_WR_KILL;
      tick(2);
      chk(snoop_tt_o, f[0] ? BEGM_TT_WR_FLUSH : BEGM_TT_WR_KILL);
      bridge_tt_i = 5'h0a;
      tick(2);
      chk(snoop_tt_o, 5'h0a);
    end
  endtask : t_snoop
  task automatic t_req;
    int hi = 0;
    int lo = 0;
    br_n = 1'b0;
    go = 1'b1;
    for (int i = 0; i < 12 && pci_frame_n_i; i++)
      tick();
    chk({4'h0, pci_frame_n_i}, 5'h0);
    chk({4'h0, bridge_frame_n_o}, 5'h1);
    // New address and byte enables must reach the bridge at a PCI edge
    ad_hi = 2'h1;
    cbe_n = 4'ha;
    for (int i = 0; i < 40; i++)
    begin
      tick();
      hi += (reqs === 5'h3);
      lo += (reqs === 5'h0);
    end
    chk({3'h0, hi > 8, lo > 8}, 5'h3);
    chk({4'h0, bridge_frame_n_o}, 5'h0);
    chk({bridge_ad_hi_o, bridge_cbe_n_o[2:0]}, 5'h0a);
    go = 1'b0;
    tick(12);
    chk(reqs, 5'h0);
  endtask : t_req
  task automatic t_disc;
    go = 1'b1;
    disc = 1'b1;
    wait_stop();
    disc = 1'b0;
    go = 1'b0;
    cnt = 0;
    for (int i = 0; i < 40; i++)
    begin
      tick();
      cnt += (grants === 5'h3);
    end
    chk({4'h0, cnt >= 9 && cnt <= 20}, 5'h1);
  endtask : t_disc
  task automatic t_async;
    async_l2_i = 1'b1;
    data_bus_busy_n_i = 1'b0;
    tick(2);
    pci_gnt_n_i = 1'b1;
    tick(3);
    chk(grants, 5'h3);
    for (int k = 0; k < 2; k++)
    begin
      address_bus_busy_n_i = 1'b0;
      tick();
      address_bus_busy_n_i = 1'b1;
      tick(2);
      chk(grants, k ? 5'h0 : 5'h3);
    end
    data_bus_busy_n_i = 1'b1;
    async_l2_i = 1'b0;
  endtask : t_async
  task automatic t_ta;
    transfer_type_i = 5'h12;
    data_bus_busy_n_i = 1'b0;
    bridge_ta_oe_i = 1'b1;
    bridge_ta_n_i = 1'b0;
    tick();
    chk(ta, 5'h2);
    tick(2);
    chk(ta, 5'h3);
    bridge_ta_n_i = 1'b1;
    data_bus_busy_n_i = 1'b1;
    tick(2);
    // The bench models no L2, so a claiming target is allowed here
    proc_target_claim_n_i = 1'b0;
    tick(2);
    chk({4'h0, transfer_acknowledge_oe_o}, 5'h0);
    proc_target_claim_n_i = 1'b1;
  endtask : t_ta
  initial
  begin
    tick(12);
    chk(grants, 5'h3);
    rst_b_i = 1'b1;
    tick(2);
    chk(grants, 5'h0);
    t_address_acknowledge_n();
    t_snoop();
    t_req();
    t_disc();
    t_async();
    t_ta();
    test_done();
  end
endmodule : test_bridge_errata_grant_masking
